// [urx_recovery.sv]
// Asynchronous receive clock and data recovery front end.
// Assumes frame_bits_i is 5..10 and stable while a frame is received.
`timescale 1ns/10ps
// Notes on behaviour
// - Sixteen samples per bit normally, eight with double speed select.
// - Falling edge while idle starts detection; first low sample is number one.
// - Start qualified on samples 8,9,10 normally, 4,5,6 in double speed.
// - Two or more high qualification samples: drop as noise, watch again.
// - Qualified start realigns the bit counter, for every frame.
// - Per-bit state sequence of sixteen or eight states numbers each sample.
// - Bit value is the majority of three centre samples.
// - Voting samples are states 8,9,10 normally or 4,5,6 double speed.
// - Recover data, parity if any, and first stop bit only.
// - Stop bit voted like others; zero sets the frame error flag.
// - New falling edge accepted right after last stop voting sample.
// - Data plus parity length of five to ten bits sets bits before stop.
// - Receiver and transmitter each take half the tolerable mismatch.
// - Frame error presented together with the frame's data.
module urx_recovery
  import urx_pkg::*;
#(
  parameter int DIV_W = URX_DIV_W
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic rx_enable_i,
  input wire logic double_speed_select_i,
  input wire logic [DIV_W-1:0] baud_divisor_i,
  input wire logic [3:0] frame_bits_i,
  input wire logic rxd_i,
  output logic [9:0] rx_data_o,
  output logic frame_error_flag_o,
  output logic rx_valid_o,
  output logic rx_busy_o
);

  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic prev;
    urx_state_e st;
    logic [4:0] cnt;
    logic [3:0] idx;
    logic [1:0] votes;
    logic [9:0] shift;
    logic [9:0] data;
    logic ferr;
    logic valid;
    logic busy;
  } urx_rx_s;

  urx_rx_s r;
  urx_rx_s next_r;
  logic tick;
  logic div_rst;
  logic [4:0] s_bit;
  logic [4:0] v_first;
  logic [4:0] v_mid;
  logic [4:0] v_last;
  logic [4:0] smp;
  logic vote;

  // Divider held in reset while disabled so timing restarts cleanly
  assign div_rst = rst_i | ~rx_enable_i;

  urx_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(div_rst),
    .baud_divisor_i(baud_divisor_i), // Exact divisor keeps our half of the rate budget
    .tick_o(tick)
  );

  // Mode-dependent sample counts and voting positions
  assign s_bit = double_speed_select_i ? URX_OS_DOUBLE : URX_OS_NORMAL;
  assign v_first = double_speed_select_i ? URX_VOTE_FIRST_DOUBLE : URX_VOTE_FIRST_NORMAL;
  assign v_mid = v_first + 5'h01;
  assign v_last = v_first + 5'h02;
  // Sample taken at this tick; cnt still holds the number of the one before
  assign smp = r.cnt + 5'h01;
  // Third sample is the live one, so the decision costs no extra tick
  assign vote = urx_majority(r.votes[0], r.votes[1], r.sync2);

  // Recovery state machine, advanced once per sample tick
  always_comb
  begin
    next_r = r;
    next_r.valid = 1'b0;
    next_r.sync1 = rxd_i;
    next_r.sync2 = r.sync1;
    if (!rx_enable_i)
    begin
      // Abandon any frame; old data and flag stay on the outputs
      next_r.st = URX_IDLE;
      next_r.busy = 1'b0;
      next_r.cnt = 5'h00;
      next_r.idx = 4'h0;
      next_r.prev = 1'b0;
    end
    else if (tick)
    begin
      next_r.prev = r.sync2;
      unique case (r.st)
        URX_IDLE:
        begin
          // Needs a high sample first, so a held break is no edge
          if (r.prev && !r.sync2)
          begin
            next_r.st = URX_START;
            next_r.cnt = 5'h01;
            next_r.busy = 1'b1;
          end
        end
        URX_START:
        begin
          next_r.cnt = r.cnt + 5'h01;
          if (smp == v_first)
          begin
            next_r.votes[0] = r.sync2;
          end
          if (smp == v_mid)
          begin
            next_r.votes[1] = r.sync2;
          end
          if (smp == v_last && vote)
          begin
            next_r.st = URX_IDLE;
            next_r.busy = 1'b0;
          end
          else if (r.cnt == s_bit)
          begin
            next_r.st = URX_BITS;
            next_r.cnt = 5'h01;
            next_r.idx = 4'h0;
            next_r.shift = 10'h000;
          end
        end
        URX_BITS:
        begin
          next_r.cnt = r.cnt + 5'h01;
          if (smp == v_first)
          begin
            next_r.votes[0] = r.sync2;
          end
          if (smp == v_mid)
          begin
            next_r.votes[1] = r.sync2;
          end
          if (smp == v_last)
          begin
            if (r.idx >= frame_bits_i)
            begin
              // First stop bit: later stop bits are never looked at
              next_r.data = r.shift;
              next_r.ferr = ~vote;
              next_r.valid = 1'b1;
              next_r.st = URX_IDLE;
              next_r.busy = 1'b0;
            end
            else
            begin
              next_r.shift[r.idx] = vote;
            end
          end
          else if (r.cnt == s_bit)
          begin
            next_r.cnt = 5'h01;
            next_r.idx = r.idx + 4'h1;
          end
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= URX_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rx_data_o = r.data;
  assign frame_error_flag_o = r.ferr;
  assign rx_valid_o = r.valid;
  assign rx_busy_o = r.busy;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_edge_idle;
    rx_enable_i && tick && r.st == URX_IDLE && r.prev && !r.sync2;
  endsequence

  sequence s_stop_decide;
    rx_enable_i && tick && r.st == URX_BITS && smp == v_last && r.idx >= frame_bits_i;
  endsequence

  property p_sync_delay;
    ##2 1'b1 |-> r.sync2 == $past(rxd_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

  property p_start_detect;
    s_edge_idle |=> r.st == URX_START && r.cnt == 5'h01 && rx_busy_o;
  endproperty
  a_start_detect: assert property (p_start_detect) else $error("start not seen");

  property p_noise_reject;
    rx_enable_i && tick && r.st == URX_START && smp == v_last && vote |=> r.st == URX_IDLE;
  endproperty
  a_noise_reject: assert property (p_noise_reject) else $error("noise kept");

  property p_realign;
    rx_enable_i && tick && r.st == URX_START && r.cnt == s_bit
      |=> r.st == URX_BITS && r.cnt == 5'h01 && r.idx == 4'h0;
  endproperty
  a_realign: assert property (p_realign) else $error("no realign");

  property p_cnt_range;
    r.st != URX_IDLE |-> r.cnt >= 5'h01 && r.cnt <= s_bit;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("sample count range");

  property p_cnt_step;
    rx_enable_i && tick && r.st == URX_BITS && r.cnt != s_bit && smp != v_last
      |=> r.cnt == $past(r.cnt) + 5'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("state step wrong");

  property p_stop_frame;
    s_stop_decide ##0 (vote == 1'b0)
      |=> rx_valid_o && frame_error_flag_o && r.st == URX_IDLE;
  endproperty
  a_stop_frame: assert property (p_stop_frame) else $error("frame error missed");

  property p_stop_good;
    s_stop_decide ##0 vote |=> rx_valid_o && !frame_error_flag_o;
  endproperty
  a_stop_good: assert property (p_stop_good) else $error("false frame error");

  property p_valid_cause;
    rx_valid_o |-> $past(r.st) == URX_BITS && $past(smp) == $past(v_last);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("stray valid");

  property p_disable;
    !rx_enable_i |=> r.st == URX_IDLE && !rx_busy_o;
  endproperty
  a_disable: assert property (p_disable) else $error("disable not immediate");

endmodule : urx_recovery

// [urx_pkg.sv]
// Shared constants for the asynchronous receive recovery block.
// Assumes a single system clock and a sample tick from the divisor.
package urx_pkg;

  // Samples per bit period
  localparam logic [4:0] URX_OS_NORMAL = 5'h10;
  localparam logic [4:0] URX_OS_DOUBLE = 5'h08;

  // First centre (voting) sample per mode; middle and last follow it
  localparam logic [4:0] URX_VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] URX_VOTE_FIRST_DOUBLE = 5'h04;

  // Data plus parity length limits
  localparam logic [3:0] URX_BITS_MIN = 4'h5;
  localparam logic [3:0] URX_BITS_MAX = 4'ha;

  // Divisor width and reset value
  localparam int URX_DIV_W = 12;
  localparam logic [URX_DIV_W-1:0] URX_DIV_RESET = 12'h000;

  // Recovery states
  typedef enum logic [1:0]
  {
    URX_IDLE,
    URX_START,
    URX_BITS
  } urx_state_e;

  // Two-of-three vote, used for start qualification and every bit
  function automatic logic urx_majority(input logic a, input logic b, input logic c);
    urx_majority = (a & b) | (a & c) | (b & c);
  endfunction : urx_majority

endpackage : urx_pkg

// [urx_tick_gen.sv]
// Sample tick divider for the receive recovery block.
// Assumes the divisor is stable while the receiver is enabled.
`timescale 1ns/10ps
module urx_tick_gen
  import urx_pkg::*;
#(
  parameter int DIV_W = URX_DIV_W
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [DIV_W-1:0] baud_divisor_i,
  output logic tick_o
);

  typedef struct packed
  {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } urx_div_s;

  urx_div_s r;
  urx_div_s next_r;

  // Count down; one tick every divisor plus one cycles
  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt == '0)
    begin
      next_r.cnt = baud_divisor_i;
      next_r.tick = 1'b1;
    end
    else
    begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // Reset clears the count so the first tick comes one cycle after reset is released
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      r.cnt <= URX_DIV_RESET;
      r.tick <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign tick_o = r.tick;

endmodule : urx_tick_gen

// [urx_tx_model.sv]
// Remote asynchronous transmitter model driving the serial receive line.
// Assumes one caller at a time and a line that idles high.
`timescale 1ns/10ps
module urx_tx_model
(
  input wire logic clk_sys_i,
  output logic rxd_o
);
  initial rxd_o = 1'b1;

  // Drive a level for n clocks, changing just after an edge
  task automatic hold(input logic v, input int n);
    @(posedge clk_sys_i);
    rxd_o <= #1 v;
    repeat (n - 1) @(posedge clk_sys_i);
  endtask : hold

  // Caller keeps the period within half the tolerable mismatch
  task automatic send(input logic [9:0] data, input int nbits, input logic stop,
                      input int period, input bit short_stop);
    int i;
    // Zero bits: a lone spike, too short to pass start qualification
    if (nbits == 0)
    begin
      hold(1'b0, period / 4);
      hold(1'b1, period);
    end
    else
    begin
      hold(1'b0, period);
      for (i = 0; i < nbits; i++)
        hold(data[i], period);
      // Short stop lets the next start follow the voting window at once
      hold(stop, short_stop ? period * 3 / 4 : period);
      rxd_o <= #1 1'b1;
      // A low stop needs an idle stretch before the next edge counts
      if (!stop)
        hold(1'b1, period);
    end
  endtask : send
endmodule : urx_tx_model

// [tb_urx_recovery.sv]
// Self-checking bench for the receive recovery front end.
// Assumes the transmitter model is the only driver of the serial line.
`timescale 1ns/10ps
module tb_urx_recovery;
  import urx_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_enable_i = 1'b0;
  logic double_speed_select_i = 1'b0;
  logic [URX_DIV_W-1:0] baud_divisor_i = 12'h004;
  logic [3:0] frame_bits_i = 4'h8;
  logic rxd;
  logic [9:0] rx_data_o;
  logic frame_error_flag_o;
  logic rx_valid_o;
  logic rx_busy_o;
  logic [10:0] exp_q[$];
  logic [10:0] exp_word;
  int n_fail = 0;
  int total_checks = 0;
  int seed = 51916;
  int cycles = 0;
  int per;

  urx_recovery DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rx_enable_i(rx_enable_i),
    .double_speed_select_i(double_speed_select_i), .baud_divisor_i(baud_divisor_i),
    .frame_bits_i(frame_bits_i), .rxd_i(rxd), .rx_data_o(rx_data_o),
    .frame_error_flag_o(frame_error_flag_o), .rx_valid_o(rx_valid_o), .rx_busy_o(rx_busy_o));

  urx_tx_model u_tx (.clk_sys_i(clk_sys_i), .rxd_o(rxd));

  // 200 MHz system clock
  initial
  begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic results;
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // Inputs move a fixed 1 ns after the rising edge
  task automatic step;
    @(posedge clk_sys_i);
    #1;
  endtask : step

  // Bits at or above the frame length read as zero
  function automatic logic [9:0] expect_data(input logic [9:0] d, input int n);
    expect_data = d & ((10'h001 << n) - 10'h001);
  endfunction : expect_data

  task automatic frame(input int nbits, input logic stop, input bit short_stop, input int skew);
    logic [9:0] d;
    // Length moves only after the previous frame's stop vote
    repeat (2) step();
    d = 10'($random(seed));
    per = (double_speed_select_i ? 8 : 16) * (int'(baud_divisor_i) + 1);
    if (nbits != 0)
    begin
      frame_bits_i = 4'(nbits);
      exp_q.push_back({~stop, expect_data(d, nbits)});
    end
    u_tx.send(d, nbits, stop, per + skew, short_stop);
  endtask : frame

  // Scoreboard on each valid pulse, read mid-cycle; cycle ceiling cuts a hang short
  always @(negedge clk_sys_i)
  begin
    cycles++;
    if (rx_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected frame", 10'h001, 10'h000);
      else
      begin
        exp_word = exp_q.pop_front();
        check("data", rx_data_o, exp_word[9:0]);
        check("frame error", {9'h000, frame_error_flag_o}, {9'h000, exp_word[10]});
      end
    end
    if (cycles == 90000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    rx_enable_i = 1'b1;
    repeat (100) step();
    // Random frames: both modes, every length, short stops, bad stops, small skew
    for (int k = 0; k < 24; k++)
    begin
      // Mode moves only once the last stop vote is surely over
      repeat (k[0] ? 1 : 40) step();
      double_speed_select_i = k[1];
      baud_divisor_i = 12'(3 + ($random(seed) & 3));
      frame(5 + k % 6, (k % 5) != 4, ($random(seed) & 1) == 1,
            (!k[1] && baud_divisor_i > 12'h004) ? ($random(seed) % 2) : 0);
    end
    // Noise spikes in both modes are dropped
    for (int m = 0; m < 2; m++)
    begin
      repeat (40) step();
      double_speed_select_i = m[0];
      frame(0, 1'b1, 1'b0, 0);
      check("busy after spike", {9'h000, rx_busy_o}, 10'h000);
    end
    // Disable in mid-frame abandons it
    step();
    double_speed_select_i = 1'b0;
    per = 16 * (int'(baud_divisor_i) + 1);
    fork
      u_tx.send(10'h0a5, 8, 1'b1, per, 1'b0);
      begin
        repeat (per * 3) step();
        check("busy in frame", {9'h000, rx_busy_o}, 10'h001);
        rx_enable_i = 1'b0;
        repeat (2) step();
        check("busy after disable", {9'h000, rx_busy_o}, 10'h000);
      end
    join
    repeat (per) step();
    rx_enable_i = 1'b1;
    repeat (per) step();
    frame(8, 1'b1, 1'b0, 0);
    repeat (per) step();
    check("frames pending", 10'(exp_q.size()), 10'h000);
    results();
  end
endmodule : tb_urx_recovery
